// ===== qpc_chopper_config.v
// Purpose: Configuration register and amplitude logic of the quiet chopper
// Assumes: Synchronous inputs, one clock, plain register port
// Notes: Bridge drive is reported as decoded controls only
// Notes: Status at 0x40 and internal scale at 0x44 are read-only
// Notes: Gain code zero leaves the automatic scale unchanged on half waves; a switchback still caps it
`timescale 1ns/1ns
`include "qpc_regs.vh"
module qpc_chopper_config
(
   input wire sys_clk_in,
   input wire reset_n_in,
   input wire clk_en_in,
   input wire [7:0] addr_in,
   input wire [31:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   output reg [31:0] rdata_out,
   input wire [4:0] run_current_setting_in,
   input wire [4:0] hold_current_setting_in,
   input wire [4:0] current_scale_now_in,
   input wire [19:0] measured_step_time_in,
   input wire standstill_in,
   input wire half_wave_in,
   input wire fullstep_in,
   input wire switchback_in,
   input wire [7:0] scale_target_in,
   input wire grad_up_in,
   input wire grad_down_in,
   output reg [7:0] amplitude_out,
   output reg [7:0] tuned_gradient_value_out,
   output reg regulation_active_out,
   output reg slow_decay_lowside_sense_out,
   output reg zero_current_standstill_option_out,
   output reg short_lowside_out,
   output reg short_highside_out,
   output reg [1:0] chopper_frequency_select_out
);
   ////////////////////////////////////////////////////////////////////
   // Synchronised reset, register storage and regulation state
   reg rst_s1;
   reg rst_s2;
   reg [31:0] quiet_chopper_config;
   reg [8:0] scale_auto; // Automatic scale, one fractional bit
   reg [3:0] fs_count;
   reg grad_up_pend;
   reg grad_down_pend;
   reg [8:0] next_scale_auto;
   reg [7:0] next_amplitude;
   reg reg_on;
   wire [7:0] ff_amp;
   // Field views of the configuration register
   wire [3:0] lim = quiet_chopper_config[`QPC_LIM_HI:`QPC_LIM_LO];
   wire [3:0] gain = quiet_chopper_config[`QPC_REG_HI:`QPC_REG_LO];
   wire autoscale = quiet_chopper_config[`QPC_AUTOSCALE];
   wire autograd = quiet_chopper_config[`QPC_AUTOGRAD];
   wire [1:0] fw = quiet_chopper_config[`QPC_FW_HI:`QPC_FW_LO];
   wire [7:0] grad_user = quiet_chopper_config[`QPC_GRAD_HI:`QPC_GRAD_LO];
   // Gradient in use: tuned value only while both automatic modes run
   wire [7:0] grad_use = (autograd && autoscale) ? tuned_gradient_value_out : grad_user;

   // Step a value toward a target by at most a given amount
   // Never overshoots, so the target is reached exactly
   function [8:0] step_toward;
      input [8:0] cur;
      input [8:0] tgt;
      input [8:0] amt;
      begin
         if (tgt > cur)
            step_toward = (tgt - cur > amt) ? cur + amt : tgt;
         else
            step_toward = (cur - tgt > amt) ? cur - amt : tgt;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Reset release through two flip-flops
   always @(posedge sys_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
      end
      else
      begin
         rst_s1 <= 1'b1;
         rst_s2 <= rst_s1;
      end
   end

   // Feed-forward amplitude, also used for the gradient term
   qpc_ff_amp i_qpc_ff_amp
   (
      .amplitude_offset_in(quiet_chopper_config[`QPC_OFS_HI:`QPC_OFS_LO]),
      .current_scale_now_in(current_scale_now_in),
      .gradient_in(grad_use),
      .measured_step_time_in(measured_step_time_in),
      .amplitude_out(ff_amp)
   );

   ////////////////////////////////////////////////////////////////////
   // Regulation and amplitude selection
   always @*
   begin
      reg_on = !(quiet_chopper_config[`QPC_DIS_STST] && standstill_in
                 && (hold_current_setting_in < run_current_setting_in));
      // Hold the scale unless a switchback or half wave moves it
      next_scale_auto = scale_auto;
      if (switchback_in)
      begin
         // Only the automatic scale is capped, not the gradient
         if (scale_auto[8:5] > lim)
            next_scale_auto = {lim, 5'h1f};
      end
      else if (autoscale && reg_on && half_wave_in)
         next_scale_auto = step_toward(scale_auto, {scale_target_in, 1'b0},
                                       {5'h00, gain});
      if (autoscale)
         next_amplitude = next_scale_auto[8:1];
      else
         next_amplitude = ff_amp;
   end

   ////////////////////////////////////////////////////////////////////
   // Register, regulation state and outputs
   always @(posedge sys_clk_in or negedge rst_s2)
   begin
      if (!rst_s2)
      begin
         quiet_chopper_config <= `QPC_CONFIG_RESET;
         scale_auto <= 9'h000;
         fs_count <= 4'h0;
         grad_up_pend <= 1'b0;
         grad_down_pend <= 1'b0;
         rdata_out <= 32'h0000_0000;
         amplitude_out <= 8'h00;
         tuned_gradient_value_out <= 8'h00;
         regulation_active_out <= 1'b1;
         slow_decay_lowside_sense_out <= 1'b0;
         zero_current_standstill_option_out <= 1'b0;
         short_lowside_out <= 1'b0;
         short_highside_out <= 1'b0;
         chopper_frequency_select_out <= 2'h0;
      end
      else if (clk_en_in)
      begin
         // Register write, config address only
         if (wr_in && addr_in == `QPC_ADDR_CONFIG)
            quiet_chopper_config <= wdata_in;
         // Read data valid the cycle after the strobe only
         if (rd_in)
         begin
            case (addr_in)
               `QPC_ADDR_CONFIG: rdata_out <= quiet_chopper_config;
               `QPC_ADDR_STATUS: rdata_out <= {15'h0000, reg_on, tuned_gradient_value_out,
                                               amplitude_out};
               `QPC_ADDR_INPUTS: rdata_out <= {23'h00_0000, scale_auto};
               default: rdata_out <= 32'h0000_0000;
            endcase
         end
         else
         begin
            rdata_out <= 32'h0000_0000;
         end
         // Automatic scale, amplitude and regulation flag
         scale_auto <= next_scale_auto;
         amplitude_out <= next_amplitude;
         regulation_active_out <= autoscale && reg_on;
         // Gradient tracking: one unit per eight full steps
         if (!autograd || !autoscale)
         begin
            tuned_gradient_value_out <= grad_user;
            fs_count <= 4'h0;
            grad_up_pend <= 1'b0;
            grad_down_pend <= 1'b0;
         end
         else
         begin
            if (grad_up_in)
               grad_up_pend <= 1'b1;
            if (grad_down_in)
               grad_down_pend <= 1'b1;
            if (fullstep_in)
            begin
               if (fs_count == `QPC_GRAD_FULLSTEPS - 4'h1)
               begin
                  fs_count <= 4'h0;
                  grad_up_pend <= grad_up_in;
                  grad_down_pend <= grad_down_in;
                  if (grad_up_pend && !grad_down_pend && tuned_gradient_value_out != 8'hff)
                     tuned_gradient_value_out <= tuned_gradient_value_out + 8'h01;
                  else if (grad_down_pend && !grad_up_pend
                           && tuned_gradient_value_out != 8'h00)
                     tuned_gradient_value_out <= tuned_gradient_value_out - 8'h01;
               end
               else
                  fs_count <= fs_count + 4'h1;
            end
         end
         // Field copies to the bridge control
         slow_decay_lowside_sense_out <= quiet_chopper_config[`QPC_MEAS_SD];
         chopper_frequency_select_out <= quiet_chopper_config[`QPC_FREQ_HI:`QPC_FREQ_LO];
         // Zero hold current standstill options
         zero_current_standstill_option_out <= standstill_in && hold_current_setting_in == 5'h00
                          && fw == `QPC_FW_FREE;
         short_lowside_out <= standstill_in && hold_current_setting_in == 5'h00
                              && fw == `QPC_FW_SHORT_LS;
         short_highside_out <= standstill_in && hold_current_setting_in == 5'h00
                               && fw == `QPC_FW_SHORT_HS;
      end
   end
endmodule

// ===== qpc_regs.vh
// Purpose: Constants for the quiet chopper configuration block
// Assumes: Included by the block's design files
// Notes: Offsets are byte addresses on the plain register port
`ifndef QPC_REGS_VH
`define QPC_REGS_VH
`define QPC_ADDR_CONFIG 8'h3c
`define QPC_ADDR_STATUS 8'h40
`define QPC_ADDR_INPUTS 8'h44
`define QPC_CONFIG_RESET 32'hc40c_001d
`define QPC_LIM_HI 31
`define QPC_LIM_LO 28
`define QPC_REG_HI 27
`define QPC_REG_LO 24
`define QPC_DIS_STST 23
`define QPC_MEAS_SD 22
`define QPC_FW_HI 21
`define QPC_FW_LO 20
`define QPC_AUTOGRAD 19
`define QPC_AUTOSCALE 18
`define QPC_FREQ_HI 17
`define QPC_FREQ_LO 16
`define QPC_GRAD_HI 15
`define QPC_GRAD_LO 8
`define QPC_OFS_HI 7
`define QPC_OFS_LO 0
`define QPC_FW_NORMAL 2'h0
`define QPC_FW_FREE 2'h1
`define QPC_FW_SHORT_LS 2'h2
`define QPC_FW_SHORT_HS 2'h3
`define QPC_GRAD_FULLSTEPS 4'h8
`endif

// ===== qpc_ff_amp.v
// Purpose: Feed-forward amplitude from offset, current scale and gradient
// Assumes: Combinational, operands steady within a cycle
// Notes: Step time zero is treated as maximum speed contribution clamp
`timescale 1ns/1ns
module qpc_ff_amp
(
   input wire [7:0] amplitude_offset_in,
   input wire [4:0] current_scale_now_in,
   input wire [7:0] gradient_in,
   input wire [19:0] measured_step_time_in,
   output reg [7:0] amplitude_out
);
   reg [12:0] ofs_part;
   reg [27:0] grad_part;
   reg [28:0] sum;
   // Offset*(cs+1)/32 plus gradient*256/step time, clamped to 255
   always @*
   begin
      ofs_part = amplitude_offset_in * ({8'h00, current_scale_now_in} + 13'h0001);
      if (measured_step_time_in == 20'h0_0000)
         grad_part = 28'h000_00ff;
      else
         grad_part = {gradient_in, 20'h0_0000} / {8'h00, measured_step_time_in} >> 12;
      sum = {21'h00_0000, ofs_part[12:5]} + {1'b0, grad_part};
      amplitude_out = (sum > 29'h0000_00ff) ? 8'hff : sum[7:0];
   end
endmodule

// ===== qpc_chk.sv
// Purpose: Port assertions for the quiet chopper configuration block
// Assumes: Clock enable held high; shadow config follows writes
// Notes: Bound to the block after the module
`timescale 1ns/1ns
`include "qpc_regs.vh"
module qpc_chk
(
   input wire sys_clk_in, reset_n_in, clk_en_in, wr_in, rd_in,
   input wire standstill_in, switchback_in,
   input wire [7:0] addr_in, amplitude_out, tuned_gradient_value_out,
   input wire [31:0] wdata_in, rdata_out,
   input wire [4:0] run_current_setting_in, hold_current_setting_in, current_scale_now_in,
   input wire [19:0] measured_step_time_in,
   input wire regulation_active_out, slow_decay_lowside_sense_out,
   input wire zero_current_standstill_option_out, short_lowside_out, short_highside_out
);
// Shadow of the config register, updated like the real one
reg [31:0] cfg;
always @(posedge sys_clk_in or negedge reset_n_in)
   if (!reset_n_in) cfg <= `QPC_CONFIG_RESET;
   else if (clk_en_in && wr_in && addr_in == `QPC_ADDR_CONFIG) cfg <= wdata_in;
// Expected decodes from shadow and inputs
wire rd_cfg = rd_in && addr_in == `QPC_ADDR_CONFIG;
wire [3:0] dec = 4'h1 << cfg[21:20];
wire [2:0] opt = (standstill_in && hold_current_setting_in == 5'h0) ? dec[3:1] : 3'h0;
wire red = hold_current_setting_in < run_current_setting_in;
wire reg_on = cfg[18] && !(cfg[23] && standstill_in && red);
wire man = !cfg[18];
wire usr_g = !(cfg[19] && cfg[18]);
wire [31:0] ff = ((cfg[7:0] * (current_scale_now_in + 32'h1)) >> 5) +
   ((measured_step_time_in == 20'h0) ? 32'hff : (cfg[15:8] * 32'h100) / measured_step_time_in);
wire [7:0] ffc = (ff > 32'hff) ? 8'hff : ff[7:0];
default clocking @(posedge sys_clk_in); endclocking
default disable iff (!reset_n_in);
a_read_back: assert property ($past(rd_cfg) |-> rdata_out == $past(cfg))
   else $error("config read data wrong");
a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
   else $error("read data not zero outside read");
a_sense_copy: assert property (slow_decay_lowside_sense_out == $past(cfg[22]))
   else $error("sense enable wrong");
a_standstill_opt: assert property ({short_highside_out, short_lowside_out, zero_current_standstill_option_out} == $past(opt))
   else $error("standstill option wrong");
a_reg_gate: assert property (regulation_active_out == $past(reg_on))
   else $error("regulation gate wrong");
a_manual_amp: assert property ($past(man) |-> amplitude_out == $past(ffc))
   else $error("manual amplitude wrong");
a_user_grad: assert property ($past(usr_g) |-> tuned_gradient_value_out == $past(cfg[15:8]))
   else $error("user gradient not used");
a_switch_cap: assert property (switchback_in && cfg[18] |-> ##1 amplitude_out[7:4] <= cfg[31:28])
   else $error("switchback cap exceeded");
endmodule
bind qpc_chopper_config qpc_chk i_qpc_chk (.sys_clk_in, .reset_n_in, .clk_en_in, .wr_in, .rd_in,
   .standstill_in, .switchback_in, .addr_in, .amplitude_out, .tuned_gradient_value_out,
   .wdata_in, .rdata_out, .run_current_setting_in, .hold_current_setting_in,
   .current_scale_now_in, .measured_step_time_in, .regulation_active_out,
   .slow_decay_lowside_sense_out, .zero_current_standstill_option_out, .short_lowside_out, .short_highside_out);

// ===== stepper_pwm_chopper_config_tb_top.sv
// Purpose: Self-checking bench for the quiet chopper configuration block
// Assumes: Plain register port, clock enable held high
// Notes: Automatic scale read back at 0x44 in half units
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; $display("BAD %s exp %h got %h", n, e, g); end end
module stepper_pwm_chopper_config_tb_top;
reg sys_clk = 0, rst_n = 0, wr = 0, rd = 0, stst = 0, hw = 0, sb = 0, fs = 0, gu = 0, gd = 0;
reg [7:0] addr = 0;
reg [31:0] wdata = 0, d0, d1;
reg [4:0] run = 5'h10, hold = 5'h0, cs = 5'h1f;
reg [19:0] measured_step_time = 20'h100;
wire [31:0] rdata;
wire [7:0] amp, grad;
wire ra, sense, fw, sl, sh;
wire [1:0] freq;
integer error_cnt = 0, n_compared = 0, cyc = 0, i;
always #5 sys_clk = ~sys_clk;
qpc_chopper_config i_qpc_chopper_config (.sys_clk_in(sys_clk), .reset_n_in(rst_n),
   .clk_en_in(1'b1), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
   .run_current_setting_in(run), .hold_current_setting_in(hold), .current_scale_now_in(cs),
   .measured_step_time_in(measured_step_time), .standstill_in(stst), .half_wave_in(hw), .fullstep_in(fs),
   .switchback_in(sb), .scale_target_in(8'hff), .grad_up_in(gu), .grad_down_in(gd),
   .amplitude_out(amp), .tuned_gradient_value_out(grad), .regulation_active_out(ra),
   .slow_decay_lowside_sense_out(sense), .zero_current_standstill_option_out(fw), .short_lowside_out(sl),
   .short_highside_out(sh), .chopper_frequency_select_out(freq));
// Register port cycles
task wr_reg(input [7:0] a, input [31:0] d);
begin
   @(posedge sys_clk); addr <= a; wdata <= d; wr <= 1'b1;
   @(posedge sys_clk); wr <= 1'b0;
end
endtask
task rd_reg(input [7:0] a, output [31:0] d);
begin
   @(posedge sys_clk); addr <= a; rd <= 1'b1;
   @(posedge sys_clk); rd <= 1'b0;
   #1 d = rdata;
end
endtask
task half_wave;
begin
   @(posedge sys_clk); hw <= 1'b1;
   @(posedge sys_clk); hw <= 1'b0;
end
endtask
// One full step pulse with optional tuner requests
task full_step(input up, input dn);
begin
   @(posedge sys_clk); fs <= 1'b1; gu <= up; gd <= dn;
   @(posedge sys_clk); fs <= 1'b0; gu <= 1'b0; gd <= 1'b0;
end
endtask
task give_verdict;
begin
   $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
   if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
   else $display("Run complete: FAIL");
   $finish;
end
endtask
// Hang guard
always @(posedge sys_clk)
begin
   cyc <= cyc + 1;
   if (cyc == 3000) begin error_cnt++; give_verdict; end
end
initial
begin
   repeat (3) @(posedge sys_clk); rst_n <= 1'b1;
   repeat (3) @(posedge sys_clk);
   rd_reg(8'h3c, d0); `CHK("cfg reset", 32'hc40c_001d, d0)
   wr_reg(8'h40, 32'h0); rd_reg(8'h3c, d0); `CHK("ro write", 32'hc40c_001d, d0)
   rd_reg(8'h50, d0); `CHK("unmapped", 32'h0, d0)
   wr_reg(8'h3c, 32'h5a5a_a5a5); rd_reg(8'h3c, d0); `CHK("pattern", 32'h5a5a_a5a5, d0)
   `CHK("freq copy", 2'h2, freq)
   $display("Test registers done");
   for (i = 1; i < 16; i = i + 7)
   begin
      wr_reg(8'h3c, 32'hc00c_001d | (i << 24));
      rd_reg(8'h44, d0); half_wave; rd_reg(8'h44, d1);
      `CHK("scale step", i[8:0], d1[8:0] - d0[8:0])
   end
   $display("Test gain done");
   for (i = 0; i < 40; i = i + 1) half_wave;
   wr_reg(8'h3c, 32'h2f0c_001d);
   @(posedge sys_clk) sb <= 1'b1;
   @(posedge sys_clk) sb <= 1'b0;
   repeat (3) @(posedge sys_clk); #1;
   `CHK("switch amp", 8'h2f, amp)
   `CHK("switch grad", 8'ha5, grad)
   rd_reg(8'h44, d0); `CHK("switch scale", 9'h05f, d0[8:0])
   $display("Test switchback done");
   for (i = 0; i < 8; i = i + 1) full_step(i == 0, 1'b0);
   #1;
   `CHK("grad up", 8'ha6, grad)
   for (i = 0; i < 8; i = i + 1) full_step(1'b0, i == 0);
   #1;
   `CHK("grad down", 8'ha5, grad)
   $display("Test gradient done");
   @(posedge sys_clk) stst <= 1'b1;
   for (i = 0; i < 4; i = i + 1)
   begin
      wr_reg(8'h3c, 32'hc4c4_001d | (i << 20));
      repeat (2) @(posedge sys_clk); #1;
      `CHK("stst opt", (i == 0) ? 3'h0 : 3'h1 << (i - 1), {sh, sl, fw})
      `CHK("sense", 1'b1, sense)
      `CHK("reg stop", 1'b0, ra)
   end
   wr_reg(8'h3c, 32'hc40c_001d); repeat (2) @(posedge sys_clk); #1;
   `CHK("reg kept", 1'b1, ra)
   $display("Test standstill done");
   @(posedge sys_clk) stst <= 1'b0;
   wr_reg(8'h3c, 32'hc400_1040); repeat (2) @(posedge sys_clk); #1;
   `CHK("manual amp", 8'h50, amp)
   `CHK("user grad", 8'h10, grad)
   rd_reg(8'h40, d0); `CHK("status", 32'h0001_1050, d0)
   $display("Test manual done");
   give_verdict;
end
endmodule
